// *** shared/pegd_pkg.sv ***
// Package: register map, field layout, codes and timing for the port egress gate
package pegd_pkg;

  // Bus and register geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int IDX_W  = 7;                      // Event list index width
  localparam int TIME_W = 29;                     // Event time width
  localparam int EVT_DEPTH = 128;

  // Printed register indices; byte address is four times the index
  localparam logic [11:0] IDX_TAS_CTRL = 12'h920;
  localparam logic [11:0] IDX_EVT_SEL  = 12'h923;
  localparam logic [11:0] IDX_EVT_ENT  = 12'h924;
  localparam logic [11:0] IDX_DROP     = 12'hA00;
  localparam logic [11:0] IDX_MEMBER   = 12'hA04;
  localparam logic [11:0] IDX_MODE     = 12'h930;
  localparam logic [11:0] IDX_STATUS   = 12'h931;
  localparam logic [ADDR_W-1:0] ADR_TAS_CTRL = {2'b00, IDX_TAS_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] ADR_EVT_SEL  = {2'b00, IDX_EVT_SEL, 2'b00};
  localparam logic [ADDR_W-1:0] ADR_EVT_ENT  = {2'b00, IDX_EVT_ENT, 2'b00};
  localparam logic [ADDR_W-1:0] ADR_DROP     = {2'b00, IDX_DROP, 2'b00};
  localparam logic [ADDR_W-1:0] ADR_MEMBER   = {2'b00, IDX_MEMBER, 2'b00};
  localparam logic [ADDR_W-1:0] ADR_MODE     = {2'b00, IDX_MODE, 2'b00};
  localparam logic [ADDR_W-1:0] ADR_STATUS   = {2'b00, IDX_STATUS, 2'b00};

  // Field positions
  localparam int EVT_CODE_LSB = 29;               // Entry bits 31:29
  localparam int TAS_RESTRICT_BIT = 6;
  localparam int TAS_REF_LSB = 0;                 // Bits 1:0
  localparam int MODE_LSB = 4;                    // Bits 5:4
  localparam int MEMBER_W = 7;                    // Bits 6:0 of membership mask
  localparam logic [MEMBER_W-1:0] MEMBER_MASK = 7'h4F;  // Bits 5:4 are reserved and read zero
  localparam int ST_IDX_LSB = 8;                  // Status: current index at 14:8

  // Reset values
  localparam logic [1:0] DROP_RST = 2'h0;
  localparam logic [1:0] REF_RST  = 2'h0;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [IDX_W-1:0] SEL_RST = 7'h00;
  localparam logic [DATA_W-1:0] ENT_RST = 32'h00000000;

  // Event codes
  localparam logic [2:0] EVT_CLOSE  = 3'h0;
  localparam logic [2:0] EVT_GUARD  = 3'h1;
  localparam logic [2:0] EVT_OPEN   = 3'h2;
  localparam logic [2:0] EVT_REPEAT = 3'h7;

  // Shaper modes and start references
  typedef enum logic [1:0] {PEGD_SHP_NONE, PEGD_SHP_CBS, PEGD_SHP_TAS, PEGD_SHP_RSVD} pegd_shp_t;
  typedef enum logic [1:0] {PEGD_REF_NONE, PEGD_REF_SEC, PEGD_REF_PPS, PEGD_REF_CROSS} pegd_ref_t;

  // Drop modes
  localparam logic [1:0] DROP_NONE = 2'h0;

  // Target ports: 1..4 map to mask bits 0..3, port 5 to bit 6
  localparam int NUM_TGT = 5;
  localparam int PORT5_BIT = 6;
  localparam logic [2:0] PORT5_NUM = 3'h5;

  // Timing
  localparam longint CLK_PERIOD_NS = 10;
  localparam longint ONE_SEC_NS = 1000000000;
  localparam int ONE_SEC_CYC = int'(ONE_SEC_NS / CLK_PERIOD_NS);

endpackage : pegd_pkg

// *** shared/pegd_evt_if.sv ***
// Interface: event list access between the gate controller and the event store
interface pegd_evt_if;
  logic                                    sw_we;
  logic [pegd_pkg::IDX_W-1:0]              sw_idx;
  logic [pegd_pkg::DATA_W-1:0]             sw_wdata;
  logic [pegd_pkg::DATA_W-1:0]             sw_rdata;
  logic [pegd_pkg::IDX_W-1:0]              sch_idx;
  logic [pegd_pkg::DATA_W-1:0]             sch_rdata;

  modport ctrl (output sw_we, output sw_idx, output sw_wdata, output sch_idx,
                input sw_rdata, input sch_rdata);
  modport mem  (input sw_we, input sw_idx, input sw_wdata, input sch_idx,
                output sw_rdata, output sch_rdata);
endinterface : pegd_evt_if

// *** hdl/pegd_event_ram.sv ***
// Event list store: 128 entries, one software port and one schedule read port
module pegd_event_ram
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Event list access
  pegd_evt_if.mem   evt
);

  logic [pegd_pkg::DATA_W-1:0] mem_ff [pegd_pkg::EVT_DEPTH];

  // Entries reset to zero so the schedule never reads garbage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < pegd_pkg::EVT_DEPTH; i++)
        mem_ff[i] <= pegd_pkg::ENT_RST;
    end
    else if (evt.sw_we)
      mem_ff[evt.sw_idx] <= evt.sw_wdata;
  end

  // Both read ports are combinational so the selected entry is visible at once
  assign evt.sw_rdata  = mem_ff[evt.sw_idx];
  assign evt.sch_rdata = mem_ff[evt.sch_idx];

endmodule // pegd_event_ram

// *** hdl/pegd_top.sv ***
// Port egress gate and drop control: APB registers, shaper schedule, drop and membership
//
// Decided for this implementation: register access over APB.
module pegd_top
#(
  parameter int SEC_CYCLES = pegd_pkg::ONE_SEC_CYC
)
(
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [pegd_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [pegd_pkg::DATA_W-1:0]   pwdata,
  output logic [pegd_pkg::DATA_W-1:0]        prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Timing references
  input  wire logic                          pps_pin,
  input  wire logic                          ref_cross,
  // Frame decision
  input  wire logic                          frm_valid,
  input  wire logic [2:0]                    frm_prio,
  input  wire logic [2:0]                    frm_dest,
  input  wire logic                          dest_congested,
  input  wire logic [pegd_pkg::MEMBER_W-1:0] member_cfg,
  output logic                               frm_done,
  output logic                               frm_drop,
  output logic                               frm_fwd,
  output logic                               flow_ctrl,
  // Shaper gate
  output logic                               gate_open,
  output logic                               guard_band,
  output logic                               tx_allow
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks and declarations

  if (SEC_CYCLES < 2)
    $error("SEC_CYCLES must be at least 2");

  pegd_evt_if evt ();

  logic [1:0]                    drop_mode_ff;
  logic [1:0]                    ref_sel_ff;
  logic                          restrict_ff;
  logic [1:0]                    shp_mode_ff;
  logic [pegd_pkg::IDX_W-1:0]    sel_ff;
  logic [pegd_pkg::MEMBER_W-1:0] member_ff;
  logic [pegd_pkg::DATA_W-1:0]   prdata_ff;
  logic                          pready_ff;
  logic                          pslverr_ff;
  logic                          setup;
  logic                          wr_acc;
  logic                          mapped;
  logic [pegd_pkg::DATA_W-1:0]   rd_mux;
  logic                          pps_s1_ff;
  logic                          pps_s2_ff;
  logic                          pps_s3_ff;
  logic                          pps_lvl_ff;
  logic                          pps_edge;
  logic [31:0]                   sec_cnt_ff;
  logic                          sec_tick;
  logic                          tas_en;
  logic                          tas_en_d_ff;
  logic                          run_ff;
  logic                          start;
  logic [pegd_pkg::TIME_W-1:0]   cyc_ff;
  logic [pegd_pkg::IDX_W-1:0]    idx_ff;
  logic [2:0]                    cur_code;
  logic [pegd_pkg::TIME_W-1:0]   cur_time;
  logic                          hit;
  logic                          gate_ff;
  logic                          guard_ff;
  logic                          tx_allow_ff;
  logic                          done_ff;
  logic                          drop_ff;
  logic                          fwd_ff;
  logic                          fc_ff;
  logic [pegd_pkg::NUM_TGT-1:0]  tgt_ok;
  logic                          drop_now;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave

  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && pready_ff && pwrite && !pslverr_ff;

  // Address decode; anything else answers with pslverr
  always_comb
  begin
    mapped = 1'b1;
    rd_mux = '0;
    case (paddr)
      pegd_pkg::ADR_TAS_CTRL: rd_mux = 32'(restrict_ff) << pegd_pkg::TAS_RESTRICT_BIT
                                       | 32'(ref_sel_ff) << pegd_pkg::TAS_REF_LSB;
      pegd_pkg::ADR_EVT_SEL:  rd_mux = 32'(sel_ff);                 // Bit 7 reads zero
      pegd_pkg::ADR_EVT_ENT:  rd_mux = evt.sw_rdata;
      pegd_pkg::ADR_DROP:     rd_mux = 32'(drop_mode_ff);
      pegd_pkg::ADR_MEMBER:   rd_mux = 32'(member_ff);
      pegd_pkg::ADR_MODE:     rd_mux = 32'(shp_mode_ff) << pegd_pkg::MODE_LSB;
      pegd_pkg::ADR_STATUS:   rd_mux = 32'(idx_ff) << pegd_pkg::ST_IDX_LSB
                                       | 32'({run_ff, guard_ff, gate_ff});
      default:                mapped = 1'b0;
    endcase
  end

  // Answer is prepared in setup and shown for the whole access phase
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
    end
    else
    begin
      pready_ff  <= setup;
      pslverr_ff <= setup && !mapped;
      if (setup)
        prdata_ff <= pwrite ? '0 : rd_mux;
    end
  end

  // Software registers; reserved bits are dropped on write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      drop_mode_ff <= pegd_pkg::DROP_RST;
      ref_sel_ff   <= pegd_pkg::REF_RST;
      restrict_ff  <= 1'b0;
      shp_mode_ff  <= pegd_pkg::MODE_RST;
      sel_ff       <= pegd_pkg::SEL_RST;
    end
    else if (wr_acc)
    begin
      case (paddr)
        pegd_pkg::ADR_TAS_CTRL:
        begin
          restrict_ff <= pwdata[pegd_pkg::TAS_RESTRICT_BIT];
          ref_sel_ff  <= pwdata[pegd_pkg::TAS_REF_LSB +: 2];
        end
        pegd_pkg::ADR_EVT_SEL: sel_ff       <= pwdata[pegd_pkg::IDX_W-1:0];
        pegd_pkg::ADR_DROP:    drop_mode_ff <= pwdata[1:0];
        pegd_pkg::ADR_MODE:    shp_mode_ff  <= pwdata[pegd_pkg::MODE_LSB +: 2];
        default:               ;
      endcase
    end
  end

  // Entry register writes go straight into the slot that the index selects
  assign evt.sw_we    = wr_acc && (paddr == pegd_pkg::ADR_EVT_ENT);
  assign evt.sw_idx   = sel_ff;
  assign evt.sw_wdata = pwdata;
  assign evt.sch_idx  = idx_ff;

  pegd_event_ram u_ram
  (
    .clk   (clk),
    .rst_n (rst_n),
    .evt   (evt)
  );

  // Membership is read only to software and follows the switch configuration
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      member_ff <= '0;
    else
      member_ff <= member_cfg & pegd_pkg::MEMBER_MASK;
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Start references

  // Three-stage pps synchroniser; a change counts once stages two and three agree
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pps_s1_ff  <= 1'b0;
      pps_s2_ff  <= 1'b0;
      pps_s3_ff  <= 1'b0;
      pps_lvl_ff <= 1'b0;
    end
    else
    begin
      pps_s1_ff <= pps_pin;
      pps_s2_ff <= pps_s1_ff;
      pps_s3_ff <= pps_s2_ff;
      if (pps_s2_ff == pps_s3_ff)
        pps_lvl_ff <= pps_s3_ff;
    end
  end

  assign pps_edge = (pps_s2_ff == pps_s3_ff) && pps_s3_ff && !pps_lvl_ff;

  // Internal one second pulse; free running so the phase is independent of software
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sec_cnt_ff <= '0;
    else if (sec_cnt_ff == 32'(SEC_CYCLES - 1))
      sec_cnt_ff <= '0;
    else
      sec_cnt_ff <= sec_cnt_ff + 32'h00000001;
  end

  assign sec_tick = (sec_cnt_ff == 32'(SEC_CYCLES - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Time aware shaper schedule

  assign tas_en   = (shp_mode_ff == pegd_pkg::PEGD_SHP_TAS);
  assign cur_code = evt.sch_rdata[pegd_pkg::EVT_CODE_LSB +: 3];
  assign cur_time = evt.sch_rdata[pegd_pkg::TIME_W-1:0];
  assign hit      = run_ff && (cyc_ff >= cur_time);

  // Start of a cycle by the selected reference
  always_comb
  begin
    start = 1'b0;
    if (tas_en)
    begin
      case (ref_sel_ff)
        pegd_pkg::PEGD_REF_CROSS: start = ref_cross && !run_ff;
        pegd_pkg::PEGD_REF_PPS:   start = pps_edge;
        pegd_pkg::PEGD_REF_SEC:   start = sec_tick;
        pegd_pkg::PEGD_REF_NONE:  start = !tas_en_d_ff;
        default:                  start = 1'b0;
      endcase
    end
  end

  // Cycle counter and list position
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tas_en_d_ff <= 1'b0;
      run_ff      <= 1'b0;
      cyc_ff      <= '0;
      idx_ff      <= '0;
    end
    else
    begin
      tas_en_d_ff <= tas_en;
      if (!tas_en)
      begin
        run_ff <= 1'b0;
        cyc_ff <= '0;
        idx_ff <= '0;
      end
      else if (start)
      begin
        run_ff <= 1'b1;
        cyc_ff <= '0;
        idx_ff <= '0;
      end
      else if (hit && cur_code == pegd_pkg::EVT_REPEAT)
      begin
        cyc_ff <= '0;
        idx_ff <= '0;
      end
      else if (run_ff)
      begin
        cyc_ff <= cyc_ff + 29'h00000001;
        if (hit)
          idx_ff <= idx_ff + 7'h01;
      end
    end
  end

  // Gate state; reserved codes pass without effect
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gate_ff  <= 1'b1;
      guard_ff <= 1'b0;
    end
    else if (!tas_en || start)
    begin
      gate_ff  <= 1'b1;
      guard_ff <= 1'b0;
    end
    else if (hit)
    begin
      case (cur_code)
        pegd_pkg::EVT_CLOSE:
        begin
          gate_ff  <= 1'b0;
          guard_ff <= 1'b0;
        end
        pegd_pkg::EVT_GUARD: guard_ff <= 1'b1;
        pegd_pkg::EVT_OPEN:
        begin
          gate_ff  <= 1'b1;
          guard_ff <= 1'b0;
        end
        default: ;
      endcase
    end
  end

  // Restricted mode holds shaped frames until the scheduled open period
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tx_allow_ff <= 1'b1;
    else
      tx_allow_ff <= !tas_en || !restrict_ff || (gate_ff && !guard_ff);
  end

  assign gate_open  = gate_ff;
  assign guard_band = guard_ff;
  assign tx_allow   = tx_allow_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Congestion drop and membership

  // Per-target permission from the mask; VLAN state takes no part
  for (genvar t = 0; t < pegd_pkg::NUM_TGT; t++)
  begin : g_tgt
    localparam int BIT = (t == pegd_pkg::NUM_TGT - 1) ? pegd_pkg::PORT5_BIT : t;
    assign tgt_ok[t] = member_ff[BIT];
  end

  // Priorities below the mode value are discarded, so mode 00 never drops
  assign drop_now = dest_congested && ({1'b0, drop_mode_ff} > frm_prio);

  // One decision per offered frame, shown one cycle later
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      done_ff <= 1'b0;
      drop_ff <= 1'b0;
      fwd_ff  <= 1'b0;
    end
    else
    begin
      done_ff <= frm_valid;
      if (frm_valid)
      begin
        drop_ff <= drop_now;
        fwd_ff  <= !drop_now && frm_dest != 3'h0 && frm_dest <= pegd_pkg::PORT5_NUM
                   && tgt_ok[3'(frm_dest - 3'h1)];
      end
    end
  end

  // Flow control only in no-drop mode
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      fc_ff <= 1'b0;
    else
      fc_ff <= (drop_mode_ff == pegd_pkg::DROP_NONE) && dest_congested;
  end

  assign frm_done  = done_ff;
  assign frm_drop  = drop_ff;
  assign frm_fwd   = fwd_ff;
  assign flow_ctrl = fc_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_cong_mode0;
    drop_mode_ff == 2'h0 && dest_congested;
  endsequence

  no_drop_m0_a: assert property (frm_valid && drop_mode_ff == 2'h0 |=> !frm_drop && frm_done)
    else $error("frame dropped in no-drop mode");
  fc_m0_a: assert property (s_cong_mode0 |=> flow_ctrl)
    else $error("flow control missing in no-drop mode");
  fc_off_a: assert property (drop_mode_ff != 2'h0 |=> !flow_ctrl)
    else $error("flow control in a drop mode");
  drop_m1_a: assert property (frm_valid && dest_congested && drop_mode_ff == 2'h1 && frm_prio == 3'h0
                              |=> frm_drop)
    else $error("priority 0 not dropped in mode 01");
  drop_m2_a: assert property (frm_valid && dest_congested && drop_mode_ff == 2'h2
                              |=> frm_drop == ($past(frm_prio) <= 3'h1))
    else $error("mode 10 drop set wrong");
  drop_m3_a: assert property (frm_valid && dest_congested && drop_mode_ff == 2'h3
                              |=> frm_drop == ($past(frm_prio) <= 3'h2))
    else $error("mode 11 drop set wrong");
  p5_block_a: assert property (frm_valid && frm_dest == 3'h5 && !member_ff[6] |=> !frm_fwd)
    else $error("frame forwarded to blocked port 5");
  p1_pass_a: assert property (frm_valid && frm_dest == 3'h1 && member_ff[0] && !dest_congested
                              |=> frm_fwd)
    else $error("member port 1 not forwarded");
  repeat_evt_a: assert property (hit && cur_code == 3'h7 && !start && tas_en
                                 |=> idx_ff == 7'h00 && cyc_ff == '0)
    else $error("repeat event did not restart the list");
  close_evt_a: assert property (hit && cur_code == 3'h0 && !start && tas_en |=> !gate_open ##1 !tx_allow
                                || !restrict_ff)
    else $error("close event did not shut the gate");
  no_tas_a: assert property (shp_mode_ff != 2'h2 |=> !run_ff ##1 tx_allow)
    else $error("schedule active outside time aware mode");

endmodule // pegd_top

// *** testbench/tb_top.sv ***
// Self-checking bench for the port egress gate: registers, drop decisions, shaper schedule
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, pps_pin, ref_cross;
  logic        frm_valid, dest_congested, frm_done, frm_drop, frm_fwd, flow_ctrl;
  logic        gate_open, guard_band, tx_allow;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, seed, r;
  logic [2:0]  frm_prio, frm_dest;
  logic [6:0]  member_cfg;
  logic [1:0]  mode_cur;
  logic [32:0] rq[$];
  logic [2:0]  fq[$];
  logic [31:0] ev[4];
  int          error_cnt, tests_run, m, p, d, c;
  //////////////////////////////////////////////////////////////////////////////
  pegd_top #(.SEC_CYCLES(50)) dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pps_pin(pps_pin), .ref_cross(ref_cross), .frm_valid(frm_valid),
    .frm_prio(frm_prio), .frm_dest(frm_dest), .dest_congested(dest_congested),
    .member_cfg(member_cfg), .frm_done(frm_done), .frm_drop(frm_drop), .frm_fwd(frm_fwd),
    .flow_ctrl(flow_ctrl), .gate_open(gate_open), .guard_band(guard_band), .tx_allow(tx_allow));
  // Free-running system clock
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Xorshift keeps the run repeatable from a fixed seed
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // APB transfer; read expectations are queued for the monitor
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] dt, input logic [32:0] exp);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dt;
    if (!wr) rq.push_back(exp);
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1)
    begin
      error_cnt++;
      results();
    end
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // One frame decision; congestion is held so flow control lines up with the answer
  task automatic frame(input logic [2:0] pr, input logic [2:0] ds, input logic cg);
    logic dr, mb;
    dr = cg && (pr < {1'h0, mode_cur});
    mb = (ds == 3'h5) ? member_cfg[6] : (ds >= 3'h1 && ds <= 3'h4) ? member_cfg[ds-1] : 1'h0;
    @(posedge clk);
    frm_valid <= 1'h1;
    frm_prio <= pr;
    frm_dest <= ds;
    dest_congested <= cg;
    fq.push_back({mode_cur == 2'h0 && cg, dr, !dr && mb});
    @(posedge clk);
    frm_valid <= 1'h0;
  endtask
  // Bounded wait for a gate output (g selects guard band); w is the expected edge count, -1 if the phase is free
  task automatic wait_sig(input logic g, input logic v, input int w);
    int n;
    n = 0;
    while ((g ? guard_band : gate_open) !== v && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    chk({32'h0, g ? guard_band : gate_open}, {32'h0, v});
    if (w >= 0) chk(33'(n), 33'(w));
    if (n >= 400) results();
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Monitors pop the oldest note when a result appears
  always @(posedge clk)
  begin
    if (psel && penable && pready === 1'h1 && !pwrite) chk({pslverr, prdata}, rq.pop_front());
    if (frm_done === 1'h1) chk({30'h0, flow_ctrl, frm_drop, frm_fwd}, {30'h0, fq.pop_front()});
  end
  // Hang guard far above the length of the whole run
  initial
  begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    results();
  end
  // Main sequence
  initial
  begin
    {psel, penable, pwrite, pps_pin, ref_cross, frm_valid, dest_congested, rst_n} = 8'h00;
    {paddr, pwdata, frm_prio, frm_dest} = '0;
    {seed, member_cfg, mode_cur} = {32'h0707, 7'h7B, 2'h0};
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    // Reset values, read-only mask, unmapped place
    apb(1'h0, pegd_pkg::ADR_EVT_SEL, 32'h0, 33'h0);
    apb(1'h0, pegd_pkg::ADR_EVT_ENT, 32'h0, 33'h0);
    apb(1'h0, pegd_pkg::ADR_DROP, 32'h0, 33'h0);
    apb(1'h1, pegd_pkg::ADR_MEMBER, 32'hFFFFFFFF, 33'h0);
    apb(1'h0, pegd_pkg::ADR_MEMBER, 32'h0, {26'h0, member_cfg & 7'h4F});
    apb(1'h0, 16'h0000, 32'h0, 33'h100000000);
    // Index selects the entry; reserved index bit reads zero
    r = rnd();
    apb(1'h1, pegd_pkg::ADR_EVT_SEL, 32'h83, 33'h0);
    apb(1'h1, pegd_pkg::ADR_EVT_ENT, r, 33'h0);
    apb(1'h0, pegd_pkg::ADR_EVT_SEL, 32'h0, 33'h3);
    apb(1'h0, pegd_pkg::ADR_EVT_ENT, 32'h0, {1'h0, r});
    // Every drop mode against priorities 0 to 3, every target and congestion state
    for (m = 0; m < 4; m++)
    begin
      r = rnd();
      member_cfg <= r[6:0];
      apb(1'h1, pegd_pkg::ADR_DROP, {r[31:2], m[1:0]}, 33'h0);
      apb(1'h0, pegd_pkg::ADR_DROP, 32'h0, {31'h0, m[1:0]});
      mode_cur = m[1:0];
      for (p = 0; p < 4; p++)
        for (d = 0; d < 8; d++)
          for (c = 0; c < 2; c++)
            frame(p[2:0], d[2:0], c[0]);
    end
    // Schedule: close, open, guard, repeat, restricted and started by mode enable
    ev = '{{pegd_pkg::EVT_CLOSE, 29'h0A}, {pegd_pkg::EVT_OPEN, 29'h1E},
           {pegd_pkg::EVT_GUARD, 29'h32}, {pegd_pkg::EVT_REPEAT, 29'h46}};
    apb(1'h1, pegd_pkg::ADR_TAS_CTRL, 32'h40, 33'h0);
    for (m = 0; m < 4; m++)
    begin
      apb(1'h1, pegd_pkg::ADR_EVT_SEL, m, 33'h0);
      apb(1'h1, pegd_pkg::ADR_EVT_ENT, ev[m], 33'h0);
    end
    apb(1'h1, pegd_pkg::ADR_MODE, 32'h20, 33'h0);
    // Counts: start edge, event time, hit edge, then the gate is seen one edge later
    wait_sig(1'h0, 1'h0, 13);
    repeat (2) @(posedge clk);
    chk({32'h0, tx_allow}, 33'h0);
    wait_sig(1'h0, 1'h1, 18);
    wait_sig(1'h1, 1'h1, 20);
    repeat (2) @(posedge clk);
    chk({31'h0, gate_open, tx_allow}, 33'h2);
    // A broken repeat would reach the zero entry at index 4 and close far sooner
    wait_sig(1'h0, 1'h0, 29);
    // Credit shaping stops the schedule; status shows the gate forced open
    apb(1'h1, pegd_pkg::ADR_MODE, 32'h10, 33'h0);
    apb(1'h0, pegd_pkg::ADR_MODE, 32'h0, 33'h10);
    apb(1'h0, pegd_pkg::ADR_STATUS, 32'h0, 33'h1);
    // Reference crossing, unrestricted; reserved control bits are dropped
    apb(1'h1, pegd_pkg::ADR_TAS_CTRL, 32'hFFFFFF83, 33'h0);
    apb(1'h0, pegd_pkg::ADR_TAS_CTRL, 32'h0, 33'h3);
    apb(1'h1, pegd_pkg::ADR_MODE, 32'h20, 33'h0);
    apb(1'h0, pegd_pkg::ADR_STATUS, 32'h0, 33'h1);
    ref_cross <= 1'h1;
    wait_sig(1'h0, 1'h0, 13);
    chk({32'h0, tx_allow}, 33'h1);
    ref_cross <= 1'h0;
    // Pulse per second: start once the synchronised edge arrives, three edges after the pin
    apb(1'h1, pegd_pkg::ADR_MODE, 32'h10, 33'h0);
    apb(1'h1, pegd_pkg::ADR_TAS_CTRL, 32'h2, 33'h0);
    apb(1'h1, pegd_pkg::ADR_MODE, 32'h20, 33'h0);
    pps_pin <= 1'h1;
    wait_sig(1'h0, 1'h0, 16);
    pps_pin <= 1'h0;
    // Internal second: the free-running pulse phase is not tracked, only the bounded close
    apb(1'h1, pegd_pkg::ADR_MODE, 32'h10, 33'h0);
    apb(1'h1, pegd_pkg::ADR_TAS_CTRL, 32'h1, 33'h0);
    apb(1'h1, pegd_pkg::ADR_MODE, 32'h20, 33'h0);
    wait_sig(1'h0, 1'h0, -1);
    results();
  end
endmodule // tb_top
